// File: rtl/tcpc_defines.svh
`ifndef TCPC_DEFINES_SVH
`define TCPC_DEFINES_SVH
`define TCPC_OFF_CTRL2 8'h17
`define TCPC_OFF_MODE 8'h16
`define TCPC_OFF_CAP1_LO 8'h20
`define TCPC_OFF_CAP1_HI 8'h21
`define TCPC_OFF_CAP2_LO 8'h22
`define TCPC_OFF_CAP2_HI 8'h23
`define TCPC_OFF_IRQ_STAT 8'h24
`define TCPC_OFF_IRQ_MASK 8'h25
`define TCPC_OFF_DIR 8'h26
`define TCPC_BIT_C2OVF 7
`define TCPC_BIT_C1OVF 6
`define TCPC_BIT_PWM2 5
`define TCPC_BIT_PWM1 4
`define TCPC_BIT_CPSEL 3
`define TCPC_BIT_T3RUN 2
`define TCPC_BIT_T2RUN 1
`define TCPC_BIT_T1RUN 0
`define TCPC_BIT_CASCADE 3
`define TCPC_BIT_PWM2_PIN 3
`define TCPC_BIT_PWM1_PIN 2
`define TCPC_RST_CTRL2 8'h00
`define TCPC_RST_MODE 8'h00
`define TCPC_RST_DIR 8'hff
`define TCPC_IRQ_CAP1 0
`define TCPC_IRQ_CAP2 1
`define TCPC_IRQ_OVF1 2
`define TCPC_IRQ_OVF2 3
`endif

// File: rtl/tcpc_pkg.sv
package tcpc_pkg;
    typedef struct packed {
        logic [1:0] enable;
        logic [1:0] drive;
    } tcpc_pin_t;
    typedef struct packed {
        logic [15:0] value;
        logic full;
        logic overflow;
    } tcpc_cap_t;
endpackage

// File: rtl/tcpc_capture.sv
`timescale 1ns/1ps
`default_nettype none
module tcpc_capture
    import tcpc_pkg::*;
#(
    parameter int WIDTH = 16
) (
    input wire logic aclk, // System clock
    input wire logic aresetn, // Sync reset, low
    input wire logic capture_event, // Capture strobe
    input wire logic [WIDTH-1:0] count, // Third timer count
    input wire logic read_low, // Low byte read
    input wire logic read_high, // High byte read
    output logic [WIDTH-1:0] value_q, // Held capture
    output logic full_q, // Unread value held
    output logic overflow_q // Lost capture
);
    logic low_seen_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            value_q <= '0;
            full_q <= 1'b0;
            overflow_q <= 1'b0;
            low_seen_q <= 1'b0;
        end else begin
            if (capture_event && full_q) begin
                overflow_q <= 1'b1;
            end else if (full_q && (read_low || low_seen_q) && read_high) begin
                overflow_q <= 1'b0;
            end
            if (capture_event && !full_q) begin
                value_q <= count;
                full_q <= 1'b1;
                low_seen_q <= 1'b0;
            end else if (full_q) begin
                // Pair counts as read once the high byte is fetched with or after the low byte
                if ((read_low || low_seen_q) && read_high) begin
                    full_q <= 1'b0;
                    low_seen_q <= 1'b0;
                end else if (read_low || read_high) begin
                    low_seen_q <= low_seen_q | read_low;
                end
            end
        end
    end

    full_blocks_a: assert property (@(posedge aclk) disable iff (!aresetn)
        full_q && capture_event |=> $stable(value_q) && overflow_q)
        else $error("capture overwrote unread value");
    load_empty_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !full_q && capture_event |=> value_q == $past(count) && full_q)
        else $error("capture not loaded");
endmodule
`default_nettype wire

// File: rtl/tcpc_top.sv
// Function
// - A capture on channel two while its value is unread sets the channel-two overflow flag.
// - With select one, a capture on channel one while the shared pair is unread sets the channel-one overflow flag.
// - After an overflow the pair keeps the oldest unread captured value.
// - While a value is unread, captures are ignored until the high byte is read with or after the low byte.
// - With pwm two enabled the pin is driven by pwm two regardless of its direction bit.
// - With pwm one enabled the pin is driven by pwm one regardless of its direction bit.
// - Select one makes the shared pair the first capture and lets the third timer run freely.
// - Select zero makes the shared pair the third timer's period register.
// - The third timer runs only while its run bit is one.
// - The second timer increments only while its run bit is set.
// - The first run bit starts only the first timer; in cascade mode the upper byte of the 16-bit timer also needs the second run bit.
// - The cascade select bit joins the first and second timers into one 16-bit timer.
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "tcpc_defines.svh"
module tcpc_top
    import tcpc_pkg::*;
(
    input wire logic aclk, // System clock
    input wire logic aresetn, // Sync reset, low
    input wire logic [7:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [7:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic capture_one_in, // Channel one capture strobe
    input wire logic capture_two_in, // Channel two capture strobe
    input wire logic pwm_one_wave, // PWM1 waveform
    input wire logic pwm_two_wave, // PWM2 waveform
    input wire logic [1:0] port_out, // Port data for the two pins
    output tcpc_pin_t pin_q, // Pin enables and levels
    output logic [7:0] timer_one_q, // First timer count
    output logic [7:0] timer_two_q, // Second timer count
    output logic [15:0] third_timer_count_q, // Third timer count
    output logic irq_q // Interrupt, high
);
    logic [7:0] ctrl_q;
    logic [7:0] mode_q;
    logic [7:0] dir_q;
    logic [15:0] period_q;
    logic [3:0] stat_q;
    logic [3:0] mask_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic aw_have_q;
    logic w_have_q;
    logic [1:0] bresp_d;
    logic wr_go;
    logic rd_go;
    logic [31:0] rdata_d;
    logic rd_ok;
    logic cap1_ev;
    logic cap2_ev;
    logic [15:0] cap1_val;
    logic [15:0] cap2_val;
    logic cap1_full;
    logic cap2_full;
    logic cap1_ovf;
    logic cap2_ovf;
    logic rd_c1l;
    logic rd_c1h;
    logic rd_c2l;
    logic rd_c2h;
    logic cascade;
    logic t1_tick;
    logic t2_tick;
    logic t3_wrap;
    logic [7:0] wr_idx;
    logic [7:0] rd_idx;

    function automatic logic wr_byte0(input logic [7:0] addr, input logic [7:0] off,
                                      input logic go, input logic [3:0] strb);
        return go && (addr == off) && strb[0];
    endfunction

    // Write side: address and data latched in either order
    assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else begin
            s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_have_q && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                awaddr_q <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= bresp_d;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Byte offsets are not word aligned, so each offset is an index at four times its value
    assign wr_idx = {2'b00, awaddr_q[7:2]};
    always_comb begin
        unique case (wr_idx)
            `TCPC_OFF_CTRL2, `TCPC_OFF_MODE, `TCPC_OFF_CAP1_LO, `TCPC_OFF_CAP1_HI,
            `TCPC_OFF_IRQ_STAT, `TCPC_OFF_IRQ_MASK, `TCPC_OFF_DIR: bresp_d = 2'b00;
            default: bresp_d = 2'b10;
        endcase
    end

    function automatic logic is_wr(input logic [7:0] off);
        return wr_byte0(wr_idx, off, wr_go, wstrb_q);
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= `TCPC_RST_CTRL2;
            mode_q <= `TCPC_RST_MODE;
            dir_q <= `TCPC_RST_DIR;
            period_q <= 16'h0000;
            mask_q <= 4'h0;
        end else begin
            if (is_wr(`TCPC_OFF_CTRL2)) begin
                // Overflow bits live in the capture units; writes to them are dropped
                ctrl_q[5:0] <= wdata_q[5:0];
            end
            if (is_wr(`TCPC_OFF_MODE)) begin
                mode_q <= wdata_q[7:0];
            end
            if (is_wr(`TCPC_OFF_DIR)) begin
                dir_q <= wdata_q[7:0];
            end
            if (is_wr(`TCPC_OFF_IRQ_MASK)) begin
                mask_q <= wdata_q[3:0];
            end
            // Period writes only land while the pair is the period register
            if (!ctrl_q[`TCPC_BIT_CPSEL] && is_wr(`TCPC_OFF_CAP1_LO)) begin
                period_q[7:0] <= wdata_q[7:0];
            end
            if (!ctrl_q[`TCPC_BIT_CPSEL] && is_wr(`TCPC_OFF_CAP1_HI)) begin
                period_q[15:8] <= wdata_q[7:0];
            end
        end
    end

    // Read side
    assign rd_go = s_axi_arvalid && s_axi_arready;
    assign rd_idx = {2'b00, s_axi_araddr[7:2]};

    always_comb begin
        rdata_d = 32'h0;
        rd_ok = 1'b1;
        unique case (rd_idx)
            `TCPC_OFF_CTRL2: rdata_d[7:0] = {cap2_ovf, cap1_ovf, ctrl_q[5:0]};
            `TCPC_OFF_MODE: rdata_d[7:0] = mode_q;
            `TCPC_OFF_CAP1_LO: rdata_d[7:0] = ctrl_q[`TCPC_BIT_CPSEL] ? cap1_val[7:0]
                                                                       : period_q[7:0];
            `TCPC_OFF_CAP1_HI: rdata_d[7:0] = ctrl_q[`TCPC_BIT_CPSEL] ? cap1_val[15:8]
                                                                       : period_q[15:8];
            `TCPC_OFF_CAP2_LO: rdata_d[7:0] = cap2_val[7:0];
            `TCPC_OFF_CAP2_HI: rdata_d[7:0] = cap2_val[15:8];
            `TCPC_OFF_IRQ_STAT: rdata_d[3:0] = stat_q;
            `TCPC_OFF_IRQ_MASK: rdata_d[3:0] = mask_q;
            `TCPC_OFF_DIR: rdata_d[7:0] = dir_q;
            default: rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'b00;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rdata_d;
                s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Capture pair reads
    assign rd_c1l = rd_go && ctrl_q[`TCPC_BIT_CPSEL] && rd_idx == `TCPC_OFF_CAP1_LO;
    assign rd_c1h = rd_go && ctrl_q[`TCPC_BIT_CPSEL] && rd_idx == `TCPC_OFF_CAP1_HI;
    assign rd_c2l = rd_go && rd_idx == `TCPC_OFF_CAP2_LO;
    assign rd_c2h = rd_go && rd_idx == `TCPC_OFF_CAP2_HI;
    assign cap1_ev = capture_one_in && ctrl_q[`TCPC_BIT_CPSEL];
    assign cap2_ev = capture_two_in;

    tcpc_capture #(.WIDTH(16)) u_cap1 (
        .aclk(aclk),
        .aresetn(aresetn),
        .capture_event(cap1_ev),
        .count(third_timer_count_q),
        .read_low(rd_c1l),
        .read_high(rd_c1h),
        .value_q(cap1_val),
        .full_q(cap1_full),
        .overflow_q(cap1_ovf)
    );

    tcpc_capture #(.WIDTH(16)) u_cap2 (
        .aclk(aclk),
        .aresetn(aresetn),
        .capture_event(cap2_ev),
        .count(third_timer_count_q),
        .read_low(rd_c2l),
        .read_high(rd_c2h),
        .value_q(cap2_val),
        .full_q(cap2_full),
        .overflow_q(cap2_ovf)
    );

    // Timers; counting clock is the system clock, external sources are out of scope
    assign cascade = mode_q[`TCPC_BIT_CASCADE];
    assign t1_tick = ctrl_q[`TCPC_BIT_T1RUN];
    assign t2_tick = cascade ? (t1_tick && ctrl_q[`TCPC_BIT_T2RUN] && timer_one_q == 8'hff)
                             : ctrl_q[`TCPC_BIT_T2RUN];
    assign t3_wrap = !ctrl_q[`TCPC_BIT_CPSEL] && third_timer_count_q == period_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_one_q <= 8'h00;
            timer_two_q <= 8'h00;
            third_timer_count_q <= 16'h0000;
        end else begin
            if (t1_tick) begin
                timer_one_q <= timer_one_q + 8'h01;
            end
            if (t2_tick) begin
                timer_two_q <= timer_two_q + 8'h01;
            end
            if (ctrl_q[`TCPC_BIT_T3RUN]) begin
                // Free running when the pair serves as capture one
                third_timer_count_q <= t3_wrap ? 16'h0000
                                               : third_timer_count_q + 16'h0001;
            end
        end
    end

    // Pins: PWM enable overrides the port direction bit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_q <= '0;
        end else begin
            pin_q.enable[1] <= ctrl_q[`TCPC_BIT_PWM2] | !dir_q[`TCPC_BIT_PWM2_PIN];
            pin_q.drive[1] <= ctrl_q[`TCPC_BIT_PWM2] ? pwm_two_wave : port_out[1];
            pin_q.enable[0] <= ctrl_q[`TCPC_BIT_PWM1] | !dir_q[`TCPC_BIT_PWM1_PIN];
            pin_q.drive[0] <= ctrl_q[`TCPC_BIT_PWM1] ? pwm_one_wave : port_out[0];
        end
    end

    // Interrupts: set wins over write-one-to-clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stat_q <= 4'h0;
            irq_q <= 1'b0;
        end else begin
            stat_q <= (stat_q & ~(is_wr(`TCPC_OFF_IRQ_STAT) ? wdata_q[3:0] : 4'h0))
                      | {cap2_ev && cap2_full, cap1_ev && cap1_full,
                         cap2_ev && !cap2_full, cap1_ev && !cap1_full};
            irq_q <= |(stat_q & mask_q);
        end
    end

    ovf_readonly_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_go && wr_idx == `TCPC_OFF_CTRL2 && wstrb_q[0] && !cap1_ovf
        |=> !cap1_ovf || $past(cap1_ev))
        else $error("overflow flag written by software");
    t3_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !ctrl_q[`TCPC_BIT_T3RUN] |=> $stable(third_timer_count_q))
        else $error("third timer moved while stopped");
    t2_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !ctrl_q[`TCPC_BIT_T2RUN] |=> $stable(timer_two_q))
        else $error("second timer moved while stopped");
    t1_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !ctrl_q[`TCPC_BIT_T1RUN] |=> $stable(timer_one_q)
            && ($stable(timer_two_q) || !$past(cascade)))
        else $error("first timer moved while stopped");
    pwm2_pin_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ctrl_q[`TCPC_BIT_PWM2] |=> pin_q.enable[1] && pin_q.drive[1] == $past(pwm_two_wave))
        else $error("pwm two not on pin");
    pwm1_pin_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ctrl_q[`TCPC_BIT_PWM1] |=> pin_q.enable[0] && pin_q.drive[0] == $past(pwm_one_wave))
        else $error("pwm one not on pin");
    c2_ovf_a: assert property (@(posedge aclk) disable iff (!aresetn)
        cap2_ev && cap2_full |=> cap2_ovf)
        else $error("capture two overflow missed");
    c1_ovf_a: assert property (@(posedge aclk) disable iff (!aresetn)
        cap1_ev && cap1_full |=> cap1_ovf)
        else $error("capture one overflow missed");
    period_wrap_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ctrl_q[`TCPC_BIT_T3RUN] && t3_wrap |=> third_timer_count_q == 16'h0000)
        else $error("third timer ignored period");
    cascade_a: assert property (@(posedge aclk) disable iff (!aresetn)
        cascade && timer_one_q != 8'hff |=> $stable(timer_two_q))
        else $error("upper byte counted early");
    cov_ovf1_c: cover property (@(posedge aclk) cap1_ovf);
    cov_ovf2_c: cover property (@(posedge aclk) cap2_ovf);
    cov_cascade_c: cover property (@(posedge aclk) cascade && t2_tick);
    cov_irq_c: cover property (@(posedge aclk) irq_q);
endmodule
`default_nettype wire

// File: verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "tcpc_defines.svh"
module tb_top;
    import tcpc_pkg::*;
    localparam int N = 300;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic cap1 = 1'b0, cap2 = 1'b0;
    logic pw1 = 1'b1, pw2 = 1'b0;
    logic [1:0] port = 2'b10;
    tcpc_pin_t pin;
    logic [7:0] t1, t2;
    logic [15:0] t3;
    int fails = 0;
    int comparisons = 0;

    always #5 aclk = ~aclk;

    tcpc_top dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .capture_one_in(cap1), .capture_two_in(cap2),
        .pwm_one_wave(pw1), .pwm_two_wave(pw2), .port_out(port), .pin_q(pin),
        .timer_one_q(t1), .timer_two_q(t2), .third_timer_count_q(t3), .irq_q(irq)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        if (fails == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic timed_out();
        fails++;
        $display("mismatch at %0t: no bus answer", $time);
        summarize();
    endtask

    // Address and data offered together; each released at its own handshake
    task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
        int n;
        @(posedge aclk);
        awaddr <= {idx[5:0], 2'b00};
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (n == 100) timed_out();
        bready <= 1'b0;
        check(bresp, er);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] e, input logic [1:0] er);
        int n;
        @(posedge aclk);
        araddr <= {idx[5:0], 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (n == 100) timed_out();
        rready <= 1'b0;
        check(rresp, er);
        if (er == 2'b00) check(rdata[7:0], e);
    endtask

    // Lets registered outputs catch up before sampling off the edge
    task automatic settle();
        repeat (3) @(posedge aclk);
        #1;
    endtask

    task automatic pulse(input logic one, input logic two);
        @(posedge aclk);
        cap1 <= one;
        cap2 <= two;
        @(posedge aclk);
        cap1 <= 1'b0;
        cap2 <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask

    // Counts advance once per clock while running, so deltas over N cycles are exact
    task automatic tmr(input logic [7:0] mode, input logic [7:0] ctrl,
                       input logic e1, input logic e2, input logic comb, input logic e3);
        logic [7:0] a1, a2, b1, b2;
        logic [15:0] a3, b3, s;
        wr(`TCPC_OFF_MODE, mode, 2'b00);
        wr(`TCPC_OFF_CTRL2, ctrl, 2'b00);
        settle();
        a1 = t1;
        a2 = t2;
        a3 = t3;
        repeat (N) @(posedge aclk);
        #1;
        s = {a2, a1} + 16'(N);
        b1 = a1 + (e1 ? 8'(N) : 8'h00);
        b2 = a2 + (e2 ? 8'(N) : 8'h00);
        b3 = a3 + (e3 ? 16'(N) : 16'h0000);
        if (comb) begin
            check({t2, t1}, s);
        end else begin
            check(t1, b1);
            check(t2, b2);
        end
        check(t3, b3);
    endtask

    initial begin
        int k;
        logic [1:0] pe, dd, en, dv;
        logic [15:0] c0, c1;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        settle();
        check(pin.enable, 2'b00);
        check({t1, t2, t3}, 32'h00000000);
        check(irq, 1'b0);
        rd(`TCPC_OFF_CTRL2, 8'h00, 2'b00);
        rd(`TCPC_OFF_MODE, 8'h00, 2'b00);
        rd(`TCPC_OFF_DIR, 8'hff, 2'b00);
        wr(`TCPC_OFF_CTRL2, 8'hff, 2'b00);
        rd(`TCPC_OFF_CTRL2, 8'h3f, 2'b00);
        wr(8'h30, 8'h01, 2'b10);
        rd(8'h30, 8'h00, 2'b10);
        // Every pairing of pwm enable and direction bit on both pins
        for (k = 0; k < 16; k++) begin
            pe = k[1:0];
            dd = k[3:2];
            wr(`TCPC_OFF_CTRL2, {2'b00, pe, 4'h0}, 2'b00);
            wr(`TCPC_OFF_DIR, {4'hf, dd, 2'b11}, 2'b00);
            settle();
            en = pe | ~dd;
            dv = {pe[1] ? pw2 : port[1], pe[0] ? pw1 : port[0]};
            check(pin.enable, en);
            check(pin.drive & en, dv & en);
        end
        wr(`TCPC_OFF_CTRL2, 8'h00, 2'b00);
        // The third timer already ran a few cycles; a period below its count
        // would only be met after a full 16-bit wrap
        wr(`TCPC_OFF_CAP1_LO, 8'h80, 2'b00);
        wr(`TCPC_OFF_CAP1_HI, 8'h00, 2'b00);
        rd(`TCPC_OFF_CAP1_LO, 8'h80, 2'b00);
        rd(`TCPC_OFF_CAP1_HI, 8'h00, 2'b00);
        wr(`TCPC_OFF_CTRL2, 8'h04, 2'b00);
        repeat (N) @(posedge aclk);
        #1;
        check(t3 <= 16'h0080, 1'b1);
        pulse(1'b1, 1'b0);
        pulse(1'b1, 1'b0);
        rd(`TCPC_OFF_CTRL2, 8'h04, 2'b00);
        rd(`TCPC_OFF_IRQ_STAT, 8'h00, 2'b00);
        tmr(8'h00, 8'h0a, 1'b0, 1'b1, 1'b0, 1'b0);
        tmr(8'h00, 8'h0d, 1'b1, 1'b0, 1'b0, 1'b1);
        tmr(8'h08, 8'h0b, 1'b0, 1'b0, 1'b1, 1'b0);
        tmr(8'h08, 8'h09, 1'b1, 1'b0, 1'b0, 1'b0);
        tmr(8'h08, 8'h0a, 1'b0, 1'b0, 1'b0, 1'b0);
        wr(`TCPC_OFF_MODE, 8'h00, 2'b00);
        wr(`TCPC_OFF_CTRL2, 8'h08, 2'b00);
        settle();
        c0 = t3;
        pulse(1'b1, 1'b1);
        // Move the count on so a wrongly accepted second capture would show
        wr(`TCPC_OFF_CTRL2, 8'h0c, 2'b00);
        repeat (20) @(posedge aclk);
        wr(`TCPC_OFF_CTRL2, 8'h08, 2'b00);
        pulse(1'b1, 1'b1);
        rd(`TCPC_OFF_CTRL2, 8'hc8, 2'b00);
        rd(`TCPC_OFF_IRQ_STAT, 8'h0f, 2'b00);
        check(irq, 1'b0);
        wr(`TCPC_OFF_IRQ_MASK, 8'h04, 2'b00);
        settle();
        check(irq, 1'b1);
        wr(`TCPC_OFF_IRQ_STAT, 8'h04, 2'b00);
        settle();
        check(irq, 1'b0);
        rd(`TCPC_OFF_IRQ_STAT, 8'h0b, 2'b00);
        wr(`TCPC_OFF_IRQ_MASK, 8'h00, 2'b00);
        wr(`TCPC_OFF_IRQ_STAT, 8'h0f, 2'b00);
        rd(`TCPC_OFF_CAP1_LO, c0[7:0], 2'b00);
        rd(`TCPC_OFF_CAP1_HI, c0[15:8], 2'b00);
        rd(`TCPC_OFF_CAP2_LO, c0[7:0], 2'b00);
        rd(`TCPC_OFF_CAP2_HI, c0[15:8], 2'b00);
        rd(`TCPC_OFF_CTRL2, 8'h08, 2'b00);
        wr(`TCPC_OFF_CTRL2, 8'h0c, 2'b00);
        repeat (20) @(posedge aclk);
        wr(`TCPC_OFF_CTRL2, 8'h08, 2'b00);
        settle();
        c1 = t3;
        pulse(1'b1, 1'b1);
        rd(`TCPC_OFF_CTRL2, 8'h08, 2'b00);
        rd(`TCPC_OFF_CAP1_LO, c1[7:0], 2'b00);
        rd(`TCPC_OFF_CAP1_HI, c1[15:8], 2'b00);
        rd(`TCPC_OFF_CAP2_LO, c1[7:0], 2'b00);
        rd(`TCPC_OFF_CAP2_HI, c1[15:8], 2'b00);
        summarize();
    end
endmodule
`default_nettype wire
